// ---- logic/atsc_pkg.sv ----
// constants, field layouts and state types for the trigger sequence control
package atsc_pkg;

  // ****************************************************************
  // register map (byte addresses on the bus)
  // ****************************************************************
  localparam logic [7:0] OFS_CFG1 = 8'h00;
  localparam logic [7:0] OFS_CFG2 = 8'h04;
  localparam logic [7:0] OFS_START = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_MASK = 8'h10;
  localparam logic [7:0] OFS_DIEN = 8'h14;
  localparam logic [7:0] OFS_PORT = 8'h18;

  // ****************************************************************
  // field positions and reset values
  // ****************************************************************
  localparam int CH_NUM = 8;
  localparam int CH_W = 3;
  localparam int CFG1_SRC_BIT = 7;
  localparam int CFG2_SCAN_BIT = 0;
  localparam int CFG2_IRQEN_BIT = 1;
  localparam int CFG2_ETRIG_BIT = 2;
  localparam int CFG2_LVL_BIT = 3;
  localparam int CFG2_POL_BIT = 4;
  localparam int CFG2_WAIT_BIT = 6;
  localparam int CFG2_PWR_BIT = 7;
  localparam int START_FIRST_LSB = 4;
  localparam int START_MULT_BIT = 7;
  localparam int ST_DONE_BIT = 0;
  localparam int ST_OVR_BIT = 1;
  localparam int ST_DISC_BIT = 2;
  localparam int ST_BUSY_BIT = 16;
  localparam int ST_FLAGS_LSB = 8;
  localparam int EVT_W = 3;
  localparam logic [2:0] TRIG_CH_RST = 3'h7;
  localparam logic [7:0] START_RST = 8'h00;
  localparam logic [7:0] DIEN_RST = 8'h00;
  localparam logic [EVT_W-1:0] MASK_RST = 3'h0;

  // ****************************************************************
  // timing: one conversion, in bus clock cycles
  // ****************************************************************
  localparam int CONV_CYCLES = 16;
  localparam int CNT_W = 16;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {
    FSM_IDLE = 2'b00,
    FSM_CONV = 2'b01,
    FSM_HOLD = 2'b11
  } atsc_fsm_type;

  typedef struct packed {
    logic trig_source_select;
    logic [2:0] trig_channel_select;
  } atsc_cfg1_type;

  typedef struct packed {
    logic power_up_bit;
    logic wait_halt_bit;
    logic trig_polarity;
    logic trig_level_select;
    logic ext_trig_on;
    logic seq_done_irq_enable;
    logic scan_on;
  } atsc_cfg2_type;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
    atsc_cfg1_type cfg1;
    atsc_cfg2_type cfg2;
    logic [7:0] sequence_start_reg;
    logic [7:0] pin_buffer_enable;
    logic [EVT_W-1:0] status;
    logic [EVT_W-1:0] mask;
    logic [CH_NUM-1:0] conv_done_flag;
    logic [CH_NUM-1:0] pin_s1;
    logic [CH_NUM-1:0] pin_s2;
    logic ext_s1;
    logic ext_s2;
    logic trig_prev;
    atsc_fsm_type fsm;
    logic [CNT_W-1:0] cnt;
    logic [CH_W-1:0] idx;
    logic [CH_W-1:0] chan;
    logic resumed;
    logic active;
    logic done_pulse;
    logic irq;
  } atsc_state_type;

endpackage : atsc_pkg

// ---- logic/atsc_top.sv ----
// trigger and sequence control for an 8-channel converter, wishbone slave
//
// Notes on behaviour
// - trigger off, scan off: ignore trigger, one sequence per start, then stop
// - trigger off, scan on: ignore trigger, repeat sequences back to back
// - edge mode: one sequence per active edge; polarity 0 falling, 1 rising
// - level mode: convert continuously while trigger active; 0 low, 1 high
// - active edge while converting sets the trigger overrun flag
// - first conversion starts within one clock after the trigger is seen
// - trigger channel resets to 7 and is reassignable by configuration
// - with trigger enabled, a start register write launches nothing
// - level mode: trigger drop and return mid-sequence is no overrun
// - level mode: trigger still active at sequence end restarts at once
// - pads always feed converter; digital buffer gated per channel enable
// - stop mode halts conversion, leaving resumes; first result is suspect
// - wait mode halts when wait halt bit set; first result is suspect
// - power-up bit 0 aborts conversion; registers stay accessible
// - power-up bit resets to zero, block starts powered down
// - sequence complete interrupt gated by local enable and cpu mask
// - port bit reads pin if buffer on or pin is trigger, else 1
// - start register write clears done flags, clear beats a set
`timescale 1ns/100ps
`default_nettype none

module atsc_top #(
  parameter int CONV_CYCLES = atsc_pkg::CONV_CYCLES
) (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  // wishbone slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // pads and trigger
  input wire logic [7:0] ANALOG_PIN,
  input wire logic EXT_TRIG,
  output logic [7:0] DIG_BUF_EN,
  // low power modes and cpu interrupt mask
  input wire logic STOP_MODE,
  input wire logic WAIT_MODE,
  input wire logic CPU_IRQ_MASK,
  // converter sequencing and interrupt
  output logic CONV_ACTIVE,
  output logic [2:0] CONV_CHANNEL,
  output logic CONV_DONE,
  output logic IRQ
);

  // ****************************************************************
  // parameter check
  // ****************************************************************
  if (CONV_CYCLES < 1 || CONV_CYCLES >= (1 << atsc_pkg::CNT_W)) begin : g_chk
    $error("CONV_CYCLES out of range");
  end

  // pads, flags and channel fields are all sized for eight channels
  if (atsc_pkg::CH_NUM != 8 || atsc_pkg::CH_W != 3) begin : g_chk_ch
    $error("channel count does not match the pad ports");
  end

  localparam int CNT_LAST_I = CONV_CYCLES - 1;
  localparam logic [atsc_pkg::CNT_W-1:0] CNT_LAST =
    CNT_LAST_I[atsc_pkg::CNT_W-1:0];

  // ****************************************************************
  // state and decode signals
  // ****************************************************************
  atsc_pkg::atsc_state_type r;
  atsc_pkg::atsc_state_type n;

  logic acc;
  logic wr_fire;
  logic start_wr;
  logic trig_raw;
  logic trig_act;
  logic trig_edge;
  logic halt;
  logic launch;
  logic seq_end;
  logic overrun;
  logic discard;
  logic [atsc_pkg::EVT_W-1:0] ev_set;
  logic [atsc_pkg::EVT_W-1:0] w1c;
  logic [atsc_pkg::EVT_W-1:0] irq_en;
  logic [7:0] port_val;
  logic [31:0] rd;
  logic [atsc_pkg::CH_W-1:0] seq_last;
  logic [atsc_pkg::CH_W-1:0] first_ch;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    n = r;
    n.done_pulse = 1'b0;
    launch = 1'b0;
    seq_end = 1'b0;
    overrun = 1'b0;
    discard = 1'b0;

    // ****************************************************************
    // synchronisers and trigger detection
    // ****************************************************************
    // pads and trigger pin cross in through two flops
    n.pin_s1 = ANALOG_PIN;
    n.pin_s2 = r.pin_s1;
    n.ext_s1 = EXT_TRIG;
    n.ext_s2 = r.ext_s1;

    // trigger source: selected pad, or the dedicated pin
    trig_raw = r.cfg1.trig_source_select ? r.ext_s2 :
      r.pin_s2[r.cfg1.trig_channel_select];
    n.trig_prev = trig_raw;
    trig_act = r.cfg2.trig_polarity ? trig_raw : ~trig_raw;
    trig_edge = r.cfg2.trig_polarity ? (trig_raw & ~r.trig_prev)
      : (~trig_raw & r.trig_prev);

    // halt freezes the counter instead of aborting the sequence
    halt = STOP_MODE | (WAIT_MODE & r.cfg2.wait_halt_bit);

    // ****************************************************************
    // wishbone handshake
    // ****************************************************************
    // ack one cycle after the request, write lands with ack
    acc = WB_CYC_I & WB_STB_I;
    n.ack = acc & ~r.ack;
    // every writable field sits in byte lane 0; the other lanes are ignored
    wr_fire = acc & WB_WE_I & r.ack & WB_SEL_I[0];
    start_wr = wr_fire & (WB_ADR_I == atsc_pkg::OFS_START);
    w1c = '0;

    // ****************************************************************
    // register writes
    // ****************************************************************
    if (wr_fire) begin
      case (WB_ADR_I)
        atsc_pkg::OFS_CFG1: begin
          n.cfg1.trig_source_select = WB_DAT_I[atsc_pkg::CFG1_SRC_BIT];
          n.cfg1.trig_channel_select = WB_DAT_I[2:0];
        end
        atsc_pkg::OFS_CFG2: begin
          n.cfg2.scan_on = WB_DAT_I[atsc_pkg::CFG2_SCAN_BIT];
          n.cfg2.seq_done_irq_enable = WB_DAT_I[atsc_pkg::CFG2_IRQEN_BIT];
          n.cfg2.ext_trig_on = WB_DAT_I[atsc_pkg::CFG2_ETRIG_BIT];
          n.cfg2.trig_level_select = WB_DAT_I[atsc_pkg::CFG2_LVL_BIT];
          n.cfg2.trig_polarity = WB_DAT_I[atsc_pkg::CFG2_POL_BIT];
          n.cfg2.wait_halt_bit = WB_DAT_I[atsc_pkg::CFG2_WAIT_BIT];
          n.cfg2.power_up_bit = WB_DAT_I[atsc_pkg::CFG2_PWR_BIT];
        end
        atsc_pkg::OFS_START: n.sequence_start_reg = WB_DAT_I[7:0];
        atsc_pkg::OFS_STATUS: w1c = WB_DAT_I[atsc_pkg::EVT_W-1:0];
        atsc_pkg::OFS_MASK: n.mask = WB_DAT_I[atsc_pkg::EVT_W-1:0];
        atsc_pkg::OFS_DIEN: n.pin_buffer_enable = WB_DAT_I[7:0];
        default: begin
        end
      endcase
    end

    // length and first channel take the value being written, if any
    seq_last = n.sequence_start_reg[atsc_pkg::CH_W-1:0];
    first_ch = n.sequence_start_reg[atsc_pkg::START_FIRST_LSB +: 3];

    // ****************************************************************
    // sequencer
    // ****************************************************************
    case (r.fsm)
      atsc_pkg::FSM_IDLE: begin
        if (r.cfg2.ext_trig_on && !halt) begin
          if (r.cfg2.trig_level_select) begin
            launch = trig_act;
          end else begin
            launch = trig_edge;
          end
        end
      end
      atsc_pkg::FSM_CONV: begin
        // edges never queue: one sequence runs at a time
        if (r.cfg2.ext_trig_on && !r.cfg2.trig_level_select && trig_edge) begin
          overrun = 1'b1;
        end
        if (halt) begin
          n.fsm = atsc_pkg::FSM_HOLD;
        end else if (r.cnt == CNT_LAST) begin
          n.cnt = '0;
          n.done_pulse = 1'b1;
          n.conv_done_flag[r.idx] = 1'b1;
          if (r.resumed) begin
            discard = 1'b1;
            n.resumed = 1'b0;
          end
          if (r.idx == seq_last) begin
            seq_end = 1'b1;
            if (r.cfg2.ext_trig_on) begin
              launch = r.cfg2.trig_level_select & trig_act;
            end else begin
              launch = r.cfg2.scan_on;
            end
            if (!launch) begin
              n.fsm = atsc_pkg::FSM_IDLE;
              n.active = 1'b0;
            end
          end else begin
            n.idx = r.idx + 3'h1;
            if (r.sequence_start_reg[atsc_pkg::START_MULT_BIT]) begin
              n.chan = r.chan + 3'h1;
            end
          end
        end else begin
          n.cnt = r.cnt + 16'h0001;
        end
      end
      atsc_pkg::FSM_HOLD: begin
        if (r.cfg2.ext_trig_on && !r.cfg2.trig_level_select && trig_edge) begin
          overrun = 1'b1;
        end
        if (!halt) begin
          // the analog side is still settling; flag the next result
          n.fsm = atsc_pkg::FSM_CONV;
          n.resumed = 1'b1;
        end
      end
      default: begin
        n.fsm = atsc_pkg::FSM_IDLE;
        n.active = 1'b0;
      end
    endcase

    // ****************************************************************
    // launch, abort and done flags
    // ****************************************************************
    // software start only while the trigger is off; restarts a sequence
    if (start_wr && !r.cfg2.ext_trig_on && !halt) begin
      launch = 1'b1;
    end

    if (launch) begin
      n.fsm = atsc_pkg::FSM_CONV;
      n.active = 1'b1;
      n.cnt = '0;
      n.idx = '0;
      n.chan = first_ch;
    end

    // powering down aborts whatever runs; registers keep working
    if (!n.cfg2.power_up_bit) begin
      n.fsm = atsc_pkg::FSM_IDLE;
      n.active = 1'b0;
      n.cnt = '0;
      n.idx = '0;
      n.resumed = 1'b0;
    end

    // a start write wipes every done flag, even one set this cycle
    if (start_wr) begin
      n.conv_done_flag = '0;
    end

    // ****************************************************************
    // events and interrupt
    // ****************************************************************
    // sticky events: a set in the clearing cycle survives
    ev_set = '0;
    ev_set[atsc_pkg::ST_DONE_BIT] = seq_end & r.cfg2.power_up_bit;
    ev_set[atsc_pkg::ST_OVR_BIT] = overrun & r.cfg2.power_up_bit;
    ev_set[atsc_pkg::ST_DISC_BIT] = discard & r.cfg2.power_up_bit;
    n.status = (r.status & ~w1c) | ev_set;

    // completion also needs its local enable; cpu mask blocks all
    irq_en = r.mask;
    irq_en[atsc_pkg::ST_DONE_BIT] = r.mask[atsc_pkg::ST_DONE_BIT]
      & r.cfg2.seq_done_irq_enable;
    n.irq = ~CPU_IRQ_MASK & (|(n.status & irq_en));

    // ****************************************************************
    // read path
    // ****************************************************************
    // a trigger pad reads its level even with its buffer off
    for (int i = 0; i < atsc_pkg::CH_NUM; i++) begin
      port_val[i] = (r.pin_buffer_enable[i] || (r.cfg2.ext_trig_on
        && !r.cfg1.trig_source_select
        && r.cfg1.trig_channel_select == i[2:0]))
        ? r.pin_s2[i] : 1'b1;
    end

    rd = '0;
    case (WB_ADR_I)
      atsc_pkg::OFS_CFG1: begin
        rd[atsc_pkg::CFG1_SRC_BIT] = r.cfg1.trig_source_select;
        rd[2:0] = r.cfg1.trig_channel_select;
      end
      atsc_pkg::OFS_CFG2: begin
        rd[atsc_pkg::CFG2_SCAN_BIT] = r.cfg2.scan_on;
        rd[atsc_pkg::CFG2_IRQEN_BIT] = r.cfg2.seq_done_irq_enable;
        rd[atsc_pkg::CFG2_ETRIG_BIT] = r.cfg2.ext_trig_on;
        rd[atsc_pkg::CFG2_LVL_BIT] = r.cfg2.trig_level_select;
        rd[atsc_pkg::CFG2_POL_BIT] = r.cfg2.trig_polarity;
        rd[atsc_pkg::CFG2_WAIT_BIT] = r.cfg2.wait_halt_bit;
        rd[atsc_pkg::CFG2_PWR_BIT] = r.cfg2.power_up_bit;
      end
      atsc_pkg::OFS_START: rd[7:0] = r.sequence_start_reg;
      atsc_pkg::OFS_STATUS: begin
        rd[atsc_pkg::EVT_W-1:0] = r.status;
        rd[atsc_pkg::ST_FLAGS_LSB +: 8] = r.conv_done_flag;
        rd[atsc_pkg::ST_BUSY_BIT] = r.active;
      end
      atsc_pkg::OFS_MASK: rd[atsc_pkg::EVT_W-1:0] = r.mask;
      atsc_pkg::OFS_DIEN: rd[7:0] = r.pin_buffer_enable;
      atsc_pkg::OFS_PORT: rd[7:0] = port_val;
      default: rd = '0;
    endcase
    // taken in the request cycle so the data stands with ack
    if (acc && !r.ack) begin
      n.dat = rd;
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      r.ack <= 1'b0;
      r.dat <= '0;
      r.cfg1.trig_source_select <= 1'b0;
      r.cfg1.trig_channel_select <= atsc_pkg::TRIG_CH_RST;
      // power-up bit clear: the converter leaves reset powered down
      r.cfg2 <= '0;
      r.sequence_start_reg <= atsc_pkg::START_RST;
      r.pin_buffer_enable <= atsc_pkg::DIEN_RST;
      r.status <= '0;
      r.mask <= atsc_pkg::MASK_RST;
      r.conv_done_flag <= '0;
      r.pin_s1 <= '0;
      r.pin_s2 <= '0;
      r.ext_s1 <= 1'b0;
      r.ext_s2 <= 1'b0;
      r.trig_prev <= 1'b0;
      r.fsm <= atsc_pkg::FSM_IDLE;
      r.cnt <= '0;
      r.idx <= '0;
      r.chan <= '0;
      r.resumed <= 1'b0;
      r.active <= 1'b0;
      r.done_pulse <= 1'b0;
      r.irq <= 1'b0;
    end else begin
      r <= n;
    end
  end

  // ****************************************************************
  // outputs, all straight from flops
  // ****************************************************************
  assign WB_ACK_O = r.ack;
  assign WB_DAT_O = r.dat;
  assign DIG_BUF_EN = r.pin_buffer_enable;
  assign CONV_ACTIVE = r.active;
  assign CONV_CHANNEL = r.chan;
  assign CONV_DONE = r.done_pulse;
  assign IRQ = r.irq;

endmodule : atsc_top

`default_nettype wire

// ---- verif/atsc_top_properties.sv ----
// port-level assertions for the trigger sequence control
`timescale 1ns/100ps
`default_nettype none

module atsc_top_properties #(
  parameter int CONV_CYCLES = 16
) (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  // wishbone
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic WB_ACK_O,
  // modes and sequencing
  input wire logic STOP_MODE,
  input wire logic CPU_IRQ_MASK,
  input wire logic CONV_ACTIVE,
  input wire logic CONV_DONE,
  input wire logic IRQ
);
  // ******************
  // helper and sequences
  // ******************
  logic [7:0] gap_r;
  logic [7:0] gap_nxt;

  // saturates so a long idle spell never wraps into a short gap
  always_comb begin
    gap_nxt = (gap_r == 8'hff) ? gap_r : gap_r + 8'h01;
    if (CONV_DONE)
      gap_nxt = 8'h00;
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N)
      gap_r <= 8'hff;
    else
      gap_r <= gap_nxt;
  end

  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RESET_N);

  sequence s_req;
    WB_CYC_I && WB_STB_I && !WB_ACK_O;
  endsequence

  sequence s_stopped;
    STOP_MODE [*2];
  endsequence

  // ******************
  // checks
  // ******************
  a_ack_answers: assert property (s_req |=> WB_ACK_O)
    else $error("no ack one cycle after a request");
  a_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack longer than one cycle");
  a_ack_has_cause: assert property (
    WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I))
    else $error("ack without a request");
  a_rdata_holds: assert property (!WB_ACK_O |-> $stable(WB_DAT_O))
    else $error("read data moved between accesses");
  a_done_in_seq: assert property (CONV_DONE |-> $past(CONV_ACTIVE))
    else $error("conversion done outside a sequence");
  a_done_spacing: assert property (
    CONV_DONE |-> gap_r >= CONV_CYCLES - 1)
    else $error("conversions closer than one conversion time");
  a_stop_halts: assert property (s_stopped |=> !CONV_DONE)
    else $error("conversion finished while stopped");
  a_irq_masked: assert property ($past(CPU_IRQ_MASK) |-> !IRQ)
    else $error("interrupt raised while cpu mask set");
endmodule : atsc_top_properties

bind atsc_top atsc_top_properties #(.CONV_CYCLES(CONV_CYCLES))
  i_atsc_top_properties (
  .SYS_CLK(SYS_CLK),
  .RESET_N(RESET_N),
  .WB_CYC_I(WB_CYC_I),
  .WB_STB_I(WB_STB_I),
  .WB_DAT_O(WB_DAT_O),
  .WB_ACK_O(WB_ACK_O),
  .STOP_MODE(STOP_MODE),
  .CPU_IRQ_MASK(CPU_IRQ_MASK),
  .CONV_ACTIVE(CONV_ACTIVE),
  .CONV_DONE(CONV_DONE),
  .IRQ(IRQ)
);

`default_nettype wire

// ---- verif/atsc_trig_src.sv ----
// event source model: trigger pin and pad levels
`timescale 1ns/100ps
`default_nettype none

module atsc_trig_src (
  // clock
  input wire logic clk,
  // driven lines
  output logic trig,
  output logic [7:0] pads
);
  initial begin
    trig = 1'b0;
    pads = 8'h00;
  end

  // lines change just after an edge, promptly or after dly cycles
  task automatic put_trig(input logic v, input int dly);
    repeat (dly) @(posedge clk);
    trig <= v;
  endtask : put_trig

  task automatic put_pads(input logic [7:0] v, input int dly);
    repeat (dly) @(posedge clk);
    pads <= v;
  endtask : put_pads
endmodule : atsc_trig_src

`default_nettype wire

// ---- verif/atsc_top_test.sv ----
// self-checking bench for the trigger sequence control
`timescale 1ns/100ps
`default_nettype none

module atsc_top_test;
  // ******************
  // signals
  // ******************
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic req = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic stop = 1'b0;
  logic wait_m = 1'b0;
  logic cpu_mask = 1'b0;
  logic ack, act, done, irq, trig;
  logic [31:0] rdat, rd_q;
  logic [7:0] pads, buf_en;
  logic [2:0] chan;
  logic [15:0] lf = 16'h0001;
  int n_fail = 0;
  int num_checks = 0;
  int k, ndone, lat;

  always #2 clk = ~clk;

  // short conversions keep the run brief
  atsc_top #(.CONV_CYCLES(4)) i_atsc_top (
    .SYS_CLK(clk), .RESET_N(rst_n),
    .WB_CYC_I(req), .WB_STB_I(req), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_SEL_I(4'hf), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .ANALOG_PIN(pads), .EXT_TRIG(trig), .DIG_BUF_EN(buf_en),
    .STOP_MODE(stop), .WAIT_MODE(wait_m), .CPU_IRQ_MASK(cpu_mask),
    .CONV_ACTIVE(act), .CONV_CHANNEL(chan), .CONV_DONE(done), .IRQ(irq)
  );

  atsc_trig_src i_atsc_trig_src (.clk(clk), .trig(trig), .pads(pads));

  // ******************
  // tasks
  // ******************
  function automatic logic [15:0] nxt(input logic [15:0] s);
    nxt = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : nxt

  // tc[3] set: pad tc[2:0] is the live trigger and always reads its level
  function automatic logic [31:0] exp_port(input logic [7:0] p,
      input logic [7:0] en, input logic [3:0] tc);
    logic [7:0] v;
    v = p | ~en;
    if (tc[3])
      v[tc[2:0]] = p[tc[2:0]];
    exp_port = {24'h0, v};
  endfunction : exp_port

  task automatic final_report();
    $display("checks %0d, errors %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    int n;
    n = 0;
    req <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 40);
    rd_q = rdat;
    req <= 1'b0;
    if (ack !== 1'b1) begin
      n_fail++;
      final_report();
    end
    @(posedge clk);
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] m,
      input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(rd_q & m, e);
  endtask : rd

  task automatic run(input int n);
    ndone = 0;
    repeat (n) begin
      @(posedge clk);
      ndone += int'(done === 1'b1);
    end
  endtask : run

  task automatic wait_act(input logic v);
    lat = 0;
    while (act !== v && lat < 60) begin
      @(posedge clk);
      lat++;
    end
    if (act !== v) begin
      n_fail++;
      final_report();
    end
  endtask : wait_act

  // ******************
  // scenarios
  // ******************
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(atsc_pkg::OFS_CFG1, '1, 32'h7);
    rd(atsc_pkg::OFS_CFG2, '1, 32'h0);
    rd(atsc_pkg::OFS_PORT, '1, 32'hff);
    rd(8'h1c, '1, 32'h0);
    wr(atsc_pkg::OFS_START, 32'h83);
    run(12);
    chk(32'(ndone), 32'h0);
    wr(atsc_pkg::OFS_CFG2, 32'h82);
    wr(atsc_pkg::OFS_MASK, 32'h1);
    wr(atsc_pkg::OFS_START, 32'ha3);
    chk({29'h0, chan}, 32'h2);
    run(40);
    chk(32'(ndone), 32'h4);
    chk({29'h0, chan}, 32'h5);
    rd(atsc_pkg::OFS_STATUS, '1, 32'h0f01);
    chk({31'h0, irq}, 32'h1);
    cpu_mask <= 1'b1;
    run(2);
    chk({31'h0, irq}, 32'h0);
    cpu_mask <= 1'b0;
    wr(atsc_pkg::OFS_STATUS, 32'h1);
    run(2);
    chk({31'h0, irq}, 32'h0);
    wr(atsc_pkg::OFS_CFG2, 32'h0);
    wr(atsc_pkg::OFS_START, 32'h0);
    rd(atsc_pkg::OFS_STATUS, '1, 32'h0);
    wr(atsc_pkg::OFS_CFG2, 32'h80);
    wr(atsc_pkg::OFS_START, 32'h83);
    run(3);
    wr(atsc_pkg::OFS_CFG2, 32'h0);
    run(30);
    chk({ndone[30:0], act}, 32'h0);
    rd(atsc_pkg::OFS_CFG2, '1, 32'h0);
    wr(atsc_pkg::OFS_CFG2, 32'h81);
    wr(atsc_pkg::OFS_START, 32'h81);
    run(40);
    chk({31'h0, ndone >= 8}, 32'h1);
    stop <= 1'b1;
    // a conversion may still end on the edge that raises stop
    run(1);
    run(20);
    chk(32'(ndone), 32'h0);
    stop <= 1'b0;
    run(12);
    rd(atsc_pkg::OFS_STATUS, 32'h4, 32'h4);
    wait_m <= 1'b1;
    run(20);
    chk({31'h0, ndone > 0}, 32'h1);
    wr(atsc_pkg::OFS_CFG2, 32'hc1);
    run(20);
    chk(32'(ndone), 32'h0);
    wait_m <= 1'b0;
    wr(atsc_pkg::OFS_CFG2, 32'h80);
    wait_act(1'b0);
    wr(atsc_pkg::OFS_STATUS, 32'h7);
    for (k = 0; k < 2; k++) begin
      wr(atsc_pkg::OFS_CFG2, 32'h80);
      i_atsc_trig_src.put_pads({~k[0], 7'h0}, 0);
      run(4);
      wr(atsc_pkg::OFS_CFG2, 32'(32'h84 | (k << 4)));
      wr(atsc_pkg::OFS_START, 32'h83);
      run(12);
      chk({31'h0, act}, 32'h0);
      i_atsc_trig_src.put_pads({k[0], 7'h0}, int'(lf[1:0]));
      lf = nxt(lf);
      wait_act(1'b1);
      chk({31'h0, lat <= 6}, 32'h1);
      i_atsc_trig_src.put_pads({~k[0], 7'h0}, 0);
      i_atsc_trig_src.put_pads({k[0], 7'h0}, 2);
      wait_act(1'b0);
      rd(atsc_pkg::OFS_STATUS, 32'h2, 32'h2);
      rd(atsc_pkg::OFS_PORT, '1, exp_port({k[0], 7'h0}, 8'h0, 4'hf));
      wr(atsc_pkg::OFS_STATUS, 32'h7);
      i_atsc_trig_src.put_pads({~k[0], 7'h0}, 0);
      run(12);
      chk({31'h0, act}, 32'h0);
    end
    wr(atsc_pkg::OFS_CFG1, 32'h87);
    for (k = 0; k < 2; k++) begin
      wr(atsc_pkg::OFS_CFG2, 32'h80);
      i_atsc_trig_src.put_trig(~k[0], 0);
      run(4);
      wr(atsc_pkg::OFS_CFG2, 32'(32'h8c | (k << 4)));
      i_atsc_trig_src.put_trig(k[0], int'(lf[2:0]));
      lf = nxt(lf);
      wait_act(1'b1);
      chk({31'h0, lat <= 6}, 32'h1);
      run(6);
      i_atsc_trig_src.put_trig(~k[0], 0);
      i_atsc_trig_src.put_trig(k[0], 1);
      run(40);
      chk({31'h0, ndone >= 8}, 32'h1);
      i_atsc_trig_src.put_trig(~k[0], 0);
      wait_act(1'b0);
      rd(atsc_pkg::OFS_STATUS, 32'h2, 32'h0);
    end
    wr(atsc_pkg::OFS_CFG2, 32'h0);
    for (k = 0; k < 6; k++) begin
      lf = nxt(lf);
      i_atsc_trig_src.put_pads(lf[7:0], 0);
      wr(atsc_pkg::OFS_DIEN, {24'h0, lf[15:8]});
      run(3);
      chk({24'h0, buf_en}, {24'h0, lf[15:8]});
      rd(atsc_pkg::OFS_PORT, '1, exp_port(lf[7:0], lf[15:8], 4'h0));
    end
    final_report();
  end
endmodule : atsc_top_test

`default_nettype wire
